// ---- smtm_map.svh ----
// smtm_map.svh: constants of the temperature monitor serial slave port
//
// Contract
// RQ1: offset is 8-bit signed at location 11
// RQ2: signed offset added to each remote result
// RQ3: offset register clears to zero at reset
// RQ4: standby one-shot runs exactly one conversion
// RQ5: one-shot data byte ignored, never stored
// RQ6: each select pin resolves low, float, high
// RQ7: nine addresses from the select pin table
// RQ8: select pins latched once after power-up
// RQ9: start, then address msb first, direction
// RQ10: matching address acknowledged low before ninth
// RQ11: direction zero writes, one reads
// RQ12: byte is eight bits plus acknowledge
// RQ13: data changes only while clock low
// RQ14: master stops after last written byte
// RQ15: reader naks then stops on tenth clock
// RQ16: direction fixed until next start
// RQ17: writes one or two bytes, reads one
// RQ18: first written byte loads the pointer
// RQ19: second written byte goes to pointed register
// RQ20: one-byte write changes only the pointer
// RQ21: read returns register selected by pointer
// RQ22: separate read and write location decode
// RQ23: one-shot trigger decoded at write location 0F
// RQ24: configuration bit 6 selects standby
// RQ25: standby pin low inhibits every conversion
// RQ26: pointer never auto-increments
// RQ27: foreign addresses get no response
`ifndef SMTM_MAP_SVH
`define SMTM_MAP_SVH

// ****************************************
// register locations
// ****************************************
`define SMTM_RD_LOCAL 8'h00
`define SMTM_RD_REMOTE 8'h01
`define SMTM_RD_CONFIG 8'h03
`define SMTM_WR_CONFIG 8'h09
`define SMTM_WR_ONESHOT 8'h0F
`define SMTM_RD_OFFSET 8'h11
`define SMTM_WR_OFFSET 8'h11

// ****************************************
// fields and reset values
// ****************************************
`define SMTM_CFG_STANDBY_BIT 6
`define SMTM_CFG_WR_MASK 8'hC0
`define SMTM_CFG_RESET 8'h00
`define SMTM_OFFSET_RESET 8'h00
`define SMTM_PTR_RESET 8'h00
`define SMTM_TEMP_RESET 8'h80
`define SMTM_ADDR_SETTLE 2'h3

`endif

// ---- smtm_master_model.sv ----
// bus master model that faces the slave port across the two-wire link
`timescale 1ns/10ps
module smtm_master_model (
  input wire logic clk, // bench clock, paces the link
  input wire logic sda, // resolved data wire
  output logic scl, // link clock, stands high between frames
  output logic sda_oe // high while pulling data low
);
  // idle bus: clock driven high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ****************************************
  // bit level, 320 ns link period
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_oe = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    sda_oe = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask : stop
  // byte out, msb first, then ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask : rbyte
endmodule : smtm_master_model

// ---- smtm_pkg.sv ----
// smtm_pkg.sv: types of the temperature monitor serial slave port
package smtm_pkg;

  // ****************************************
  // serial engine states, one-hot
  // ****************************************
  typedef enum logic [6:0] {
    SMTM_IDLE = 7'b000_0001, // waiting for start
    SMTM_ADDR = 7'b000_0010, // shifting address byte
    SMTM_AACK = 7'b000_0100, // acking address
    SMTM_RX = 7'b000_1000, // shifting written byte
    SMTM_DACK = 7'b001_0000, // acking written byte
    SMTM_TX = 7'b010_0000, // sending read byte
    SMTM_TACK = 7'b100_0000 // master ack slot
  } smtm_state_e;

  // resolved level of a three-state select pin
  typedef logic [1:0] smtm_level_t;

endpackage : smtm_pkg

// ---- smtm_slave_port.sv ----
// smtm_slave_port.sv: serial slave port, pointer, offset and one-shot logic
`timescale 1ns/10ps
`include "smtm_map.svh"

module smtm_slave_port
  import smtm_pkg::*;
(
  input wire logic core_clk, // system clock, 25 MHz
  input wire logic reset, // synchronous reset, active high, acts as power-on
  input wire logic scl_in, // serial clock pin level
  input wire logic serial_data_line_in, // serial data pin level
  output logic serial_data_line_out, // serial data drive value
  output logic serial_data_line_oe, // high while pulling data low
  input wire smtm_level_t addr_select_hi_pin, // first select pin: 0 low, 1 float, 2 high
  input wire smtm_level_t addr_select_lo_pin, // second select pin: 0 low, 1 float, 2 high
  input wire logic hw_standby_pin_n, // standby pin, low inhibits conversion
  input wire logic [7:0] local_temp, // local temperature from converter
  input wire logic [7:0] raw_remote_temp, // remote result before offset
  input wire logic conv_done, // pulse: converter finished a cycle
  output logic [7:0] remote_temp_reg, // remote result with offset
  output logic conv_enable_reg, // converter may run
  output logic [6:0] dev_addr_reg, // latched bus address
  output logic dev_addr_valid_reg // address has been latched
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic scl_s1_reg; // first stage, read only by second
  logic scl_s2_reg; // synchronised clock
  logic scl_d_reg; // previous clock for edges
  logic sda_s1_reg; // first stage, read only by second
  logic sda_s2_reg; // synchronised data
  logic sda_d_reg; // previous data for edges
  logic hw_standby_pin_n_s1_reg; // standby pin first stage
  logic hw_standby_pin_n_s2_reg; // standby pin synchronised
  smtm_level_t sel_hi_s1_reg; // select pin first stage
  smtm_level_t sel_hi_s2_reg; // select pin synchronised
  smtm_level_t sel_lo_s1_reg; // select pin first stage
  smtm_level_t sel_lo_s2_reg; // select pin synchronised

  // two flops on every pin; the link clock is only sampled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      hw_standby_pin_n_s1_reg <= 1'b1;
      hw_standby_pin_n_s2_reg <= 1'b1;
      sel_hi_s1_reg <= 2'h0;
      sel_hi_s2_reg <= 2'h0;
      sel_lo_s1_reg <= 2'h0;
      sel_lo_s2_reg <= 2'h0;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= serial_data_line_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      hw_standby_pin_n_s1_reg <= hw_standby_pin_n;
      hw_standby_pin_n_s2_reg <= hw_standby_pin_n_s1_reg;
      sel_hi_s1_reg <= addr_select_hi_pin;
      sel_hi_s2_reg <= sel_hi_s1_reg;
      sel_lo_s1_reg <= addr_select_lo_pin;
      sel_lo_s2_reg <= sel_lo_s1_reg;
    end
  end

  // ****************************************
  // bus events
  // ****************************************
  logic scl_rise; // sample point of a bit
  logic scl_fall; // drive point of a bit
  logic bus_start; // start or repeated start
  logic bus_stop; // stop condition

  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  // RQ9 data falls while clock high
  assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  // RQ13 data rising in clock high ends frame
  assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // ****************************************
  // device address latch
  // ****************************************
  logic [1:0] settle_reg; // cycles since reset release
  logic [6:0] addr_lookup; // address from pin levels

  // RQ7 select pin table
  always_comb begin
    addr_lookup = 7'h18;
    // RQ6 three levels per pin
    case (sel_hi_s2_reg)
      2'h0: addr_lookup = 7'h18 + {5'h00, sel_lo_s2_reg};
      2'h1: addr_lookup = 7'h29 + {5'h00, sel_lo_s2_reg};
      default: addr_lookup = 7'h4C + {5'h00, sel_lo_s2_reg};
    endcase
    // an undefined level code on the second pin is taken as high
    if (sel_lo_s2_reg == 2'h3) begin
      addr_lookup = addr_lookup - 7'h01;
    end
  end

  // wait for the synchronisers to fill, then capture once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settle_reg <= 2'h0;
      dev_addr_reg <= 7'h00;
      dev_addr_valid_reg <= 1'b0;
    end else if (settle_reg != `SMTM_ADDR_SETTLE) begin
      settle_reg <= settle_reg + 2'h1;
    end else if (!dev_addr_valid_reg) begin
      // RQ8 latched once, later changes ignored
      dev_addr_reg <= addr_lookup;
      dev_addr_valid_reg <= 1'b1;
    end
  end

  // ****************************************
  // serial engine
  // ****************************************
  smtm_state_e state_reg; // engine state
  logic [3:0] bit_cnt_reg; // bits of current byte
  logic [7:0] rx_shift_reg; // incoming byte
  logic [7:0] tx_shift_reg; // outgoing byte
  logic [1:0] byte_idx_reg; // bytes written in this frame
  logic rd_dir_reg; // frame direction
  logic [7:0] ptr_reg; // register pointer
  logic wr_strobe; // second byte accepted
  logic [7:0] rd_data; // byte selected for reading
  logic addr_hit; // address byte matches

  // RQ27 only our latched address matches
  assign addr_hit = dev_addr_valid_reg && (rx_shift_reg[7:1] == dev_addr_reg);
  // RQ19 second byte is the data byte
  assign wr_strobe = (state_reg == SMTM_RX) && scl_fall && (bit_cnt_reg == 4'h8)
                     && (byte_idx_reg == 2'h1);

  // bit engine: sample on rise, drive on fall
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= SMTM_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      rd_dir_reg <= 1'b0;
      serial_data_line_oe <= 1'b0;
    end else if (bus_start) begin
      // RQ16 every start opens a new direction
      state_reg <= SMTM_ADDR;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      serial_data_line_oe <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= SMTM_IDLE;
      serial_data_line_oe <= 1'b0;
    end else begin
      case (state_reg)
        SMTM_ADDR: begin
          if (scl_rise) begin
            // RQ9 msb first into the shifter
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (addr_hit) begin
              // RQ10 pull low before the ninth clock
              serial_data_line_oe <= 1'b1;
              // RQ11 last bit gives the direction
              rd_dir_reg <= rx_shift_reg[0];
              state_reg <= SMTM_AACK;
            end else begin
              // RQ27 stay idle until next start
              state_reg <= SMTM_IDLE;
            end
          end
        end
        SMTM_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rd_dir_reg) begin
              // RQ21 read the pointed register
              tx_shift_reg <= rd_data;
              serial_data_line_oe <= ~rd_data[7];
              state_reg <= SMTM_TX;
            end else begin
              serial_data_line_oe <= 1'b0;
              state_reg <= SMTM_RX;
            end
          end
        end
        SMTM_RX: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            // RQ17 a third byte is not acknowledged
            if (byte_idx_reg == 2'h2) begin
              state_reg <= SMTM_IDLE;
            end else begin
              // RQ12 ninth bit is our acknowledge
              serial_data_line_oe <= 1'b1;
              byte_idx_reg <= byte_idx_reg + 2'h1;
              state_reg <= SMTM_DACK;
            end
          end
        end
        SMTM_DACK: begin
          if (scl_fall) begin
            serial_data_line_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= SMTM_RX;
          end
        end
        SMTM_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              // release for the master's ack slot
              serial_data_line_oe <= 1'b0;
              state_reg <= SMTM_TACK;
            end else begin
              // RQ13 next bit only while clock low
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              serial_data_line_oe <= ~tx_shift_reg[6];
            end
          end
        end
        SMTM_TACK: begin
          if (scl_rise) begin
            // RQ15 nak from master ends the read
            if (sda_s2_reg) begin
              state_reg <= SMTM_IDLE;
            end else begin
              bit_cnt_reg <= 4'h9;
            end
          end else if (scl_fall && bit_cnt_reg == 4'h9) begin
            // a master that keeps acking gets the same byte again
            bit_cnt_reg <= 4'h0;
            tx_shift_reg <= rd_data;
            serial_data_line_oe <= ~rd_data[7];
            state_reg <= SMTM_TX;
          end
        end
        default: begin
          state_reg <= SMTM_IDLE;
        end
      endcase
    end
  end

  // we only ever pull low; the pad pull-up makes the high level
  assign serial_data_line_out = 1'b0;

  // ****************************************
  // pointer
  // ****************************************
  // no increment anywhere, so repeated reads see one register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_reg <= `SMTM_PTR_RESET;
    end else if (state_reg == SMTM_RX && scl_fall && bit_cnt_reg == 4'h8
                 && byte_idx_reg == 2'h0) begin
      // RQ18 first byte of a write is the pointer
      ptr_reg <= rx_shift_reg;
    end
    // RQ26 otherwise pointer holds its value
  end

  // ****************************************
  // data registers
  // ****************************************
  logic [7:0] offset_reg; // signed remote offset
  logic [7:0] cfg_reg; // configuration, bits 7 and 6 kept

  // RQ20 only the second byte reaches a register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // RQ3 offset starts at zero
      offset_reg <= `SMTM_OFFSET_RESET;
      cfg_reg <= `SMTM_CFG_RESET;
    end else if (wr_strobe) begin
      // RQ22 write locations decoded apart from reads
      if (ptr_reg == `SMTM_WR_OFFSET) begin
        // RQ1 stored as two's complement
        offset_reg <= rx_shift_reg;
      end else if (ptr_reg == `SMTM_WR_CONFIG) begin
        cfg_reg <= rx_shift_reg & `SMTM_CFG_WR_MASK;
      end
    end
  end

  // read decode; write-only locations read as zero
  always_comb begin
    rd_data = 8'h00;
    // RQ22 read locations have their own decode
    if (ptr_reg == `SMTM_RD_LOCAL) begin
      rd_data = local_temp;
    end else if (ptr_reg == `SMTM_RD_REMOTE) begin
      rd_data = remote_temp_reg;
    end else if (ptr_reg == `SMTM_RD_CONFIG) begin
      rd_data = cfg_reg;
    end else if (ptr_reg == `SMTM_RD_OFFSET) begin
      rd_data = offset_reg;
    end
  end

  // ****************************************
  // remote result with offset
  // ****************************************
  logic [8:0] sum_wide; // sign-extended sum
  logic [7:0] sum_sat; // clamped to signed byte

  // RQ2 signed add, clamped rather than wrapped
  always_comb begin
    sum_wide = {raw_remote_temp[7], raw_remote_temp} + {offset_reg[7], offset_reg};
    sum_sat = sum_wide[7:0];
    // top two bits differ only on overflow
    if (sum_wide[8] != sum_wide[7]) begin
      sum_sat = sum_wide[8] ? 8'h80 : 8'h7F;
    end
  end

  // hold the last result while the converter sleeps
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remote_temp_reg <= `SMTM_TEMP_RESET;
    end else if (conv_done) begin
      remote_temp_reg <= sum_sat;
    end
  end

  // ****************************************
  // run, standby and one-shot
  // ****************************************
  logic oneshot_pending_reg; // single cycle requested
  logic soft_standby; // standby by configuration
  logic oneshot_hit; // write to the trigger location

  // RQ24 bit 6 set means standby
  assign soft_standby = cfg_reg[`SMTM_CFG_STANDBY_BIT];
  // RQ23 trigger decoded at write location 0F
  assign oneshot_hit = wr_strobe && (ptr_reg == `SMTM_WR_ONESHOT);

  // RQ5 only the write matters; the byte is dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oneshot_pending_reg <= 1'b0;
    end else if (oneshot_hit && soft_standby && hw_standby_pin_n_s2_reg) begin
      // RQ4 request one cycle, set beats done
      oneshot_pending_reg <= 1'b1;
    end else if (conv_done || !hw_standby_pin_n_s2_reg) begin
      // RQ4 back to standby after the cycle
      oneshot_pending_reg <= 1'b0;
    end
  end

  // converter gate, registered so the engine sees a clean level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_enable_reg <= 1'b0;
    end else begin
      // RQ25 standby pin low blocks everything
      conv_enable_reg <= hw_standby_pin_n_s2_reg & (~soft_standby | oneshot_pending_reg);
    end
  end

endmodule : smtm_slave_port

// ---- smtm_slave_port_props.sv ----
// checker: port-level properties of the serial slave port
`timescale 1ns/10ps
module smtm_slave_port_props
  import smtm_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic reset, // sync reset
  input wire logic serial_data_line_out, // data drive value
  input wire logic serial_data_line_oe, // data pull-down
  input wire smtm_level_t addr_select_hi_pin, // first select pin
  input wire smtm_level_t addr_select_lo_pin, // second select pin
  input wire logic hw_standby_pin_n, // standby pin
  input wire logic conv_done, // converter done
  input wire logic [7:0] remote_temp_reg, // remote result
  input wire logic conv_enable_reg, // converter may run
  input wire logic [6:0] dev_addr_reg, // latched address
  input wire logic dev_addr_valid_reg // address latched
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // row start plus column, level 3 reads as high
  function automatic logic [6:0] addr_of(input smtm_level_t h, input smtm_level_t l);
    logic [6:0] b;
    b = (h == 2'd0) ? 7'h18 : (h == 2'd1) ? 7'h29 : 7'h4C;
    return b + ((l == 2'd3) ? 7'd2 : 7'(l));
  endfunction : addr_of
  // ****************************************
  // assertions
  // ****************************************
  open_drain_a: assert property (serial_data_line_out == 1'b0) else $error("data drive not low");
  reset_vals_a: assert property (disable iff (1'b0) reset |=> remote_temp_reg == 8'h80 && !serial_data_line_oe
    && !dev_addr_valid_reg && !conv_enable_reg) else $error("bad reset state");
  addr_table_a: assert property ($rose(dev_addr_valid_reg) |-> dev_addr_reg ==
    addr_of($past(addr_select_hi_pin, 4), $past(addr_select_lo_pin, 4))) else $error("wrong address");
  addr_frozen_a: assert property (dev_addr_valid_reg && $past(dev_addr_valid_reg) |-> $stable(dev_addr_reg))
    else $error("address moved");
  hw_standby_pin_n_inhibit_a: assert property ((!hw_standby_pin_n) [*6] |-> !conv_enable_reg) else $error("runs in standby");
  remote_hold_a: assert property (!conv_done |=> $stable(remote_temp_reg)) else $error("remote changed");
  no_early_ack_a: assert property (!dev_addr_valid_reg |-> !serial_data_line_oe) else $error("early ack");
  ack_hold_a: assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe [*5]) else $error("short pull");
  cover property ($rose(serial_data_line_oe));
  cover property ($rose(dev_addr_valid_reg));
  cover property ($rose(conv_enable_reg));
endmodule : smtm_slave_port_props

bind smtm_slave_port smtm_slave_port_props smtm_slave_port_props_inst (
  .core_clk(core_clk), .reset(reset), .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe), .addr_select_hi_pin(addr_select_hi_pin),
  .addr_select_lo_pin(addr_select_lo_pin), .hw_standby_pin_n(hw_standby_pin_n), .conv_done(conv_done),
  .remote_temp_reg(remote_temp_reg), .conv_enable_reg(conv_enable_reg), .dev_addr_reg(dev_addr_reg),
  .dev_addr_valid_reg(dev_addr_valid_reg));

// ---- test_smtm_slave_port.sv ----
// testbench: slave port driven by the bus master model
`timescale 1ns/10ps
module test_smtm_slave_port;
  import smtm_pkg::*;
  logic core_clk; // 25 MHz
  logic reset; // sync, active high
  logic scl; // link clock
  logic m_oe; // master pulls data low
  logic dev_oe; // device pulls data low
  logic sda; // data wire with pull-up
  smtm_level_t hi_pin; // first select pin
  smtm_level_t lo_pin; // second select pin
  logic hw_standby_pin_n_n; // standby pin
  logic [7:0] local_t; // local reading
  logic [7:0] raw_t; // remote before offset
  logic done_p; // converter done pulse
  logic [7:0] rem_t; // remote after offset
  logic conv_en; // converter may run
  logic [6:0] dev_addr; // latched address
  logic addr_ok; // address latched
  logic [8:0] notes[$]; // expected kind and value, oldest first
  logic obs_k; // observed kind, 1 = byte
  logic [7:0] obs_v; // observed value
  event obs_ev; // a result is ready
  int bad_count; // mismatches
  int comparisons; // compares made
  logic [6:0] me; // own address
  logic [7:0] ov; // offset written
  logic [7:0] rv; // expected remote after offset
  logic [6:0] base [3] = '{7'h18, 7'h29, 7'h4C}; // first address of each table row
  assign sda = !(dev_oe | m_oe);
  smtm_master_model smtm_master_model_inst (.clk(core_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  smtm_slave_port smtm_slave_port_inst (.core_clk(core_clk), .reset(reset), .scl_in(scl),
    .serial_data_line_in(sda), .serial_data_line_out(), .serial_data_line_oe(dev_oe),
    .addr_select_hi_pin(hi_pin), .addr_select_lo_pin(lo_pin), .hw_standby_pin_n(hw_standby_pin_n_n),
    .local_temp(local_t), .raw_remote_temp(raw_t), .conv_done(done_p), .remote_temp_reg(rem_t),
    .conv_enable_reg(conv_en), .dev_addr_reg(dev_addr), .dev_addr_valid_reg(addr_ok));
  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic see(input logic k, input logic [7:0] v);
    obs_k = k;
    obs_v = v;
    -> obs_ev;
    #1;
  endtask : see
  task automatic chk(input logic k, input logic [7:0] e, input logic [7:0] g);
    notes.push_back({k, e});
    see(k, g);
  endtask : chk
  task automatic cmp_bit(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t bit %b want %b", $time, g, e);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask : cmp_byte
  // write of n bytes, ea holds expected acks: address first
  task automatic wr(input int n, input logic [23:0] d, input logic [3:0] ea);
    logic ak;
    smtm_master_model_inst.start();
    smtm_master_model_inst.wbyte({me, 1'b0}, ak);
    chk(1'b0, {7'h0, ea[3]}, {7'h0, ak});
    for (int i = 0; i < n; i++) begin
      smtm_master_model_inst.wbyte(d[23 - 8 * i -: 8], ak);
      chk(1'b0, {7'h0, ea[2 - i]}, {7'h0, ak});
    end
    smtm_master_model_inst.stop();
  endtask : wr
  task automatic rd(input logic [7:0] e);
    logic ak;
    logic [7:0] v;
    smtm_master_model_inst.start();
    smtm_master_model_inst.wbyte({me, 1'b1}, ak);
    chk(1'b0, 8'h01, {7'h0, ak});
    smtm_master_model_inst.rbyte(v);
    chk(1'b1, e, v);
    smtm_master_model_inst.stop();
  endtask : rd
  task automatic do_reset(input smtm_level_t h, input smtm_level_t l);
    reset = 1'b1;
    hi_pin = h;
    lo_pin = l;
    tick(16);
    reset = 1'b0;
    for (int i = 0; i < 20 && addr_ok !== 1'b1; i++) tick(1);
  endtask : do_reset
  task automatic pulse_done(input logic [7:0] r);
    raw_t = r;
    done_p = 1'b1;
    tick(1);
    done_p = 1'b0;
    tick(4);
  endtask : pulse_done
  task automatic end_sim();
    $display("counts: %0d compares, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // result watcher: oldest note against each result
  initial begin
    forever begin
      @(obs_ev);
      if (notes.size() == 0 || notes[0][8] !== obs_k) begin
        bad_count++;
        $display("BAD %0t unexpected result", $time);
      end else if (notes[0][8]) begin
        cmp_byte(notes[0][7:0], obs_v);
      end else begin
        cmp_bit(notes[0][0], obs_v[0]);
      end
      if (notes.size() > 0) void'(notes.pop_front());
    end
  end
  // watchdog, run needs about 3200 cycles
  initial begin
    tick(30000);
    bad_count++;
    end_sim();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    hi_pin = 2'd0;
    lo_pin = 2'd0;
    hw_standby_pin_n_n = 1'b1;
    raw_t = 8'h00;
    done_p = 1'b0;
    bad_count = 0;
    comparisons = 0;
    local_t = 8'($urandom(72));
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        do_reset(2'(h), 2'(l));
        chk(1'b1, {1'b0, base[h] + 7'(l)}, {1'b0, dev_addr});
      end
    end
    hi_pin = 2'd0;
    lo_pin = 2'd1;
    tick(10);
    chk(1'b1, {1'b0, base[2] + 7'd2}, {1'b0, dev_addr});
    hi_pin = 2'($urandom % 3);
    lo_pin = 2'($urandom % 3);
    me = base[hi_pin] + 7'(lo_pin);
    do_reset(hi_pin, lo_pin);
    rd(local_t);
    $display("address select done");
    me = me ^ 7'h01;
    wr(1, 24'h11_0000, 4'b0000);
    me = me ^ 7'h01;
    wr(1, 24'h11_0000, 4'b1100);
    rd(8'h00);
    ov = 8'($urandom);
    wr(3, {8'h11, ov, 8'h55}, 4'b1110);
    rd(ov);
    pulse_done(8'($urandom));
    rv = 8'($signed(raw_t) + $signed(ov) > 127 ? 127 : $signed(raw_t) + $signed(ov) < -128 ? -128 :
      $signed(raw_t) + $signed(ov));
    chk(1'b1, rv, rem_t);
    wr(1, 24'h01_0000, 4'b1100);
    rd(rv);
    $display("offset done");
    wr(2, 24'h09_4000, 4'b1110);
    chk(1'b0, 8'h00, {7'h0, conv_en});
    rd(8'h00);
    wr(1, 24'h03_0000, 4'b1100);
    rd(8'h40);
    wr(2, {8'h0F, 8'($urandom), 8'h00}, 4'b1110);
    chk(1'b0, 8'h01, {7'h0, conv_en});
    pulse_done(8'h12);
    chk(1'b0, 8'h00, {7'h0, conv_en});
    wr(1, 24'h0F_0000, 4'b1100);
    rd(8'h00);
    hw_standby_pin_n_n = 1'b0;
    wr(2, 24'h0F_AA00, 4'b1110);
    chk(1'b0, 8'h00, {7'h0, conv_en});
    $display("one-shot done");
    end_sim();
  end
endmodule : test_smtm_slave_port
